// File: rtl/pevg_pkg.sv
// Purpose: Shared constants and carriers of the page, event and pin logic.
// Assumes: 100 MHz system clock, 8-bit registers, 10-bit full addresses.
// Notes:   Full address is the page base plus the in-page offset.
package pevg_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Register full addresses.
  localparam logic [9:0] ADDR_PAGE_P0  = 10'h000;
  localparam logic [9:0] ADDR_PAGE_P1  = 10'h080;
  localparam logic [9:0] ADDR_PAGE_P2  = 10'h100;
  localparam logic [9:0] ADDR_PAGE_P4  = 10'h200;
  localparam logic [9:0] ADDR_STAT_IN  = 10'h050;
  localparam logic [9:0] ADDR_STAT_SUP = 10'h051;
  localparam logic [9:0] ADDR_EVT_LO   = 10'h052;
  localparam logic [9:0] ADDR_EVT_HI   = 10'h053;
  localparam logic [9:0] ADDR_MSK_LO   = 10'h054;
  localparam logic [9:0] ADDR_MSK_HI   = 10'h055;
  localparam logic [9:0] ADDR_CTRL     = 10'h056;
  localparam logic [9:0] ADDR_CFG01    = 10'h058;
  localparam logic [9:0] ADDR_CFG23    = 10'h059;
  localparam logic [9:0] ADDR_CFG4     = 10'h05a;
  localparam logic [9:0] ADDR_LOCK_LO  = 10'h0d0;
  localparam logic [9:0] ADDR_LOCK_HI  = 10'h14f;
  // Field positions and writable-bit masks.
  localparam int unsigned PG_AUTO_BIT  = 7;
  localparam int unsigned PG_WMODE_BIT = 6;
  localparam int unsigned LOCK_BIT     = 7;
  localparam logic [7:0] PG_WMASK     = 8'hc7;
  localparam logic [7:0] MSK_LO_WMASK = 8'h5f;
  localparam logic [7:0] MSK_HI_WMASK = 8'h3f;
  localparam logic [7:0] CFG4_WMASK   = 8'h0f;
  localparam logic [7:0] REG_RESET    = 8'h00;
  // Pin function codes.
  localparam logic [1:0] FN_INPUT = 2'h0;
  localparam logic [1:0] FN_TRACK = 2'h1;
  localparam logic [1:0] FN_OPEN  = 2'h2;
  localparam logic [1:0] FN_PUSH  = 2'h3;
  // Step periods of a dynamic voltage change, codes 00 to 11.
  localparam int unsigned SLEW_T0_NS = 4000;
  localparam int unsigned SLEW_T1_NS = 2000;
  localparam int unsigned SLEW_T2_NS = 1000;
  localparam int unsigned SLEW_T3_NS = 500;
  // Debounce times, counted in ticks of the base debounce period.
  localparam int unsigned DB_TICK_US = 100;
  localparam int unsigned DB_TICK_CYCLES = DB_TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned DB_T1_US = 100;
  localparam int unsigned DB_T2_US = 1000;
  localparam int unsigned DB_T3_US = 10000;
  localparam int unsigned DB_T4_US = 50000;
  localparam int unsigned DB_T5_US = 250000;
  localparam int unsigned DB_T6_US = 500000;
  localparam int unsigned DB_T7_US = 1000000;

  typedef struct packed {
    logic [1:0] ramp_ready;   // Rail B, rail A.
    logic [1:0] overcurrent;  // Rail B, rail A.
    logic       thermal_shutdown_flag;
    logic       thermal_warning;
    logic [1:0] in_range;     // Rail B, rail A.
  } pevg_supply_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       burst;
    logic       done;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pevg_acc_t;
endpackage : pevg_pkg

// File: rtl/pevg_regs.sv
// Purpose: Page selection, live status, events with masks, lock, step
//          rate and debounce timing, and general pin control.
// Assumes: Serial front end delivers decoded byte accesses on i_acc.
// Notes:   Reads answer two cycles after the access.
`timescale 1ns/1ns
module pevg_regs
  import pevg_pkg::*;
#(
  parameter int unsigned DB_TICK_LEN = DB_TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // Register access from the serial front end.
  input  wire pevg_acc_t    i_acc,
  input  wire logic         i_if_four_wire,
  output logic [7:0]        o_rdata,
  output logic              o_rvalid,
  // Registers held outside this block.
  output logic              o_ext_wr,
  output logic              o_ext_rd,
  output logic [9:0]        o_ext_addr,
  output logic [7:0]        o_ext_wdata,
  input  wire logic [7:0]   i_ext_rdata,
  // Monitored signals.
  input  wire pevg_supply_t i_supply,
  input  wire logic         i_io_supply_undervoltage,
  // General pins; index 1:0 of the bidir group is pin 3:2.
  input  wire logic [4:0]   i_pin_in,
  output logic [1:0]        o_bidir_out,
  output logic [1:0]        o_bidir_oe,
  output logic              o_track_enable,
  output logic [1:0]        o_rail_step_tick,
  output logic              o_interrupt_out_n
);
  localparam int unsigned SYNC_W = 14;

  function automatic logic [13:0] db_limit(input logic [2:0] code);
    unique case (code)
      3'h0: db_limit = 14'h0;
      3'h1: db_limit = 14'(DB_T1_US / DB_TICK_US);
      3'h2: db_limit = 14'(DB_T2_US / DB_TICK_US);
      3'h3: db_limit = 14'(DB_T3_US / DB_TICK_US);
      3'h4: db_limit = 14'(DB_T4_US / DB_TICK_US);
      3'h5: db_limit = 14'(DB_T5_US / DB_TICK_US);
      3'h6: db_limit = 14'(DB_T6_US / DB_TICK_US);
      3'h7: db_limit = 14'(DB_T7_US / DB_TICK_US);
    endcase
  endfunction

  function automatic logic [8:0] slew_limit(input logic [1:0] code);
    unique case (code)
      2'h0: slew_limit = 9'(SLEW_T0_NS / CLK_PERIOD_NS);
      2'h1: slew_limit = 9'(SLEW_T1_NS / CLK_PERIOD_NS);
      2'h2: slew_limit = 9'(SLEW_T2_NS / CLK_PERIOD_NS);
      2'h3: slew_limit = 9'(SLEW_T3_NS / CLK_PERIOD_NS);
    endcase
  endfunction

  logic [7:0]        page_ff;
  logic [7:0]        msk_lo_ff;
  logic [7:0]        msk_hi_ff;
  logic [7:0]        ctrl_ff;
  logic [7:0]        cfg01_ff;
  logic [7:0]        cfg23_ff;
  logic [7:0]        cfg4_ff;
  logic [7:0]        evt_lo_ff;
  logic [7:0]        evt_hi_ff;
  logic [7:0]        pend_lo_ff;
  logic [7:0]        pend_hi_ff;
  logic [7:0]        ptr_ff;
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic [7:0]        sup_prev_ff;
  logic              uv_prev_ff;
  logic [4:0]        act_prev_ff;
  logic [4:0]        lvl_ff;
  logic [13:0]       tick_cnt_ff;
  logic              db_tick_ff;
  logic              rd_pend_ff;
  logic              rd_ext_ff;
  logic [7:0]        rd_loc_ff;
  logic [7:0]        offs;
  logic [9:0]        full_addr;
  logic              addr_ok;
  logic              wr_ok;
  logic              locked;
  logic [7:0]        rd_mux;
  logic              rd_local;
  logic [4:0]        pin_mode;
  logic [4:0]        pin_type;
  logic [4:0]        pin_is_in;
  logic [4:0]        pin_act;
  logic [7:0]        new_lo;
  logic [7:0]        new_hi;
  logic [7:0]        clr_lo;
  logic [7:0]        clr_hi;
  pevg_supply_t      sup;
  logic              uv;

  ////////////////////////////////////////////////////////////////////////////
  // Address forming and page decoding.
  always_comb begin
    // Outside four-wire mode, repeated mode carries a fresh address with every byte.
    offs = (i_acc.burst && (i_if_four_wire || !page_ff[PG_WMODE_BIT])) ?
           8'(ptr_ff + 8'h01) : i_acc.addr;
    addr_ok   = 1'b1;
    full_addr = {3'h0, offs[6:0]};
    if (!i_if_four_wire) begin
      unique case (page_ff[2:1])
        2'h0: full_addr = {2'h0, offs};
        2'h1: full_addr = {3'h2, offs[6:0]};
        2'h2: full_addr = {3'h4, offs[6:0]};
        2'h3: addr_ok = 1'b0;
      endcase
    end else begin
      unique case (page_ff[2:0])
        3'h0: full_addr = {3'h0, offs[6:0]};
        3'h1: full_addr = {3'h1, offs[6:0]};
        3'h2: full_addr = {3'h2, offs[6:0]};
        3'h4: full_addr = {3'h4, offs[6:0]};
        default: addr_ok = 1'b0;
      endcase
    end
  end

  assign locked = ctrl_ff[LOCK_BIT] && (full_addr >= ADDR_LOCK_LO) &&
                  (full_addr <= ADDR_LOCK_HI) &&
                  (full_addr != ADDR_PAGE_P2);
  assign wr_ok  = i_acc.valid && i_acc.write && addr_ok && !locked;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ptr_ff <= 8'h00;
    end else if (i_acc.valid) begin
      ptr_ff <= offs;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Page control register.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      page_ff <= REG_RESET;
    end else if (i_acc.done && page_ff[PG_AUTO_BIT]) begin
      page_ff <= {page_ff[7:3], 3'h0};
    end else if (wr_ok && full_addr[6:0] == 7'h00 &&
                 (full_addr == ADDR_PAGE_P0 || full_addr == ADDR_PAGE_P1 ||
                  full_addr == ADDR_PAGE_P2 || full_addr == ADDR_PAGE_P4)) begin
      page_ff <= i_acc.wdata & PG_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and configuration registers.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      msk_lo_ff <= REG_RESET;
      msk_hi_ff <= REG_RESET;
      ctrl_ff   <= REG_RESET;
      cfg01_ff  <= REG_RESET;
      cfg23_ff  <= REG_RESET;
      cfg4_ff   <= REG_RESET;
    end else if (wr_ok) begin
      unique case (full_addr)
        ADDR_MSK_LO: msk_lo_ff <= i_acc.wdata & MSK_LO_WMASK;
        ADDR_MSK_HI: msk_hi_ff <= i_acc.wdata & MSK_HI_WMASK;
        ADDR_CTRL:   ctrl_ff   <= i_acc.wdata;
        ADDR_CFG01:  cfg01_ff  <= i_acc.wdata;
        ADDR_CFG23:  cfg23_ff  <= i_acc.wdata;
        ADDR_CFG4:   cfg4_ff   <= i_acc.wdata & CFG4_WMASK;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path and outside registers; two cycles for every read.
  always_comb begin
    rd_local = 1'b1;
    rd_mux   = 8'h00;
    unique case (full_addr)
      ADDR_PAGE_P0, ADDR_PAGE_P1,
      ADDR_PAGE_P2, ADDR_PAGE_P4: rd_mux = page_ff;
      ADDR_STAT_IN:  rd_mux = {3'h0, lvl_ff};
      ADDR_STAT_SUP: rd_mux = sup;
      ADDR_EVT_LO:   rd_mux = evt_lo_ff;
      ADDR_EVT_HI:   rd_mux = evt_hi_ff;
      ADDR_MSK_LO:   rd_mux = msk_lo_ff;
      ADDR_MSK_HI:   rd_mux = msk_hi_ff;
      ADDR_CTRL:     rd_mux = ctrl_ff;
      ADDR_CFG01:    rd_mux = cfg01_ff;
      ADDR_CFG23:    rd_mux = cfg23_ff;
      ADDR_CFG4:     rd_mux = cfg4_ff;
      default:       rd_local = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ext_wr    <= 1'b0;
      o_ext_rd    <= 1'b0;
      o_ext_addr  <= 10'h000;
      o_ext_wdata <= 8'h00;
      rd_pend_ff  <= 1'b0;
      rd_ext_ff   <= 1'b0;
      rd_loc_ff   <= 8'h00;
      o_rdata     <= 8'h00;
      o_rvalid    <= 1'b0;
    end else begin
      o_ext_wr    <= wr_ok && !rd_local;
      o_ext_rd    <= i_acc.valid && !i_acc.write && addr_ok && !rd_local;
      o_ext_addr  <= full_addr;
      o_ext_wdata <= i_acc.wdata;
      rd_pend_ff  <= i_acc.valid && !i_acc.write;
      rd_ext_ff   <= addr_ok && !rd_local;
      rd_loc_ff   <= addr_ok ? rd_mux : 8'h00;
      o_rvalid    <= rd_pend_ff;
      if (rd_pend_ff) begin
        o_rdata <= rd_ext_ff ? i_ext_rdata : rd_loc_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; stage one feeds stage two only.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {i_supply, i_io_supply_undervoltage, i_pin_in};
      sync2_ff <= sync1_ff;
    end
  end

  assign sup = pevg_supply_t'(sync2_ff[13:6]);
  assign uv  = sync2_ff[5];

  ////////////////////////////////////////////////////////////////////////////
  // Debounce base tick and per-pin filters.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tick_cnt_ff <= 14'h0;
      db_tick_ff  <= 1'b0;
    end else begin
      db_tick_ff  <= (tick_cnt_ff == 14'(DB_TICK_LEN - 1));
      tick_cnt_ff <= (tick_cnt_ff == 14'(DB_TICK_LEN - 1)) ? 14'h0 :
                     14'(tick_cnt_ff + 14'h1);
    end
  end

  assign pin_mode  = {cfg4_ff[3], cfg23_ff[7], cfg23_ff[3],
                      cfg01_ff[7], cfg01_ff[3]};
  assign pin_type  = {cfg4_ff[2], cfg23_ff[6], cfg23_ff[2],
                      cfg01_ff[6], cfg01_ff[2]};
  assign pin_is_in = {1'b1, cfg23_ff[5:4] == FN_INPUT,
                      cfg23_ff[1:0] == FN_INPUT, 1'b1, 1'b1};
  assign pin_act   = ~(lvl_ff ^ pin_type);

  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_pin
      logic [13:0] cnt_ff;
      logic        filt;
      // Output pins never filter their read-back level.
      assign filt = pin_mode[g] && pin_is_in[g] &&
                    (ctrl_ff[2:0] != 3'h0);
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          cnt_ff    <= 14'h0;
          lvl_ff[g] <= 1'b0;
        end else if (sync2_ff[g] == lvl_ff[g]) begin
          cnt_ff <= 14'h0;
        end else if (!filt) begin
          lvl_ff[g] <= sync2_ff[g];
        end else if (db_tick_ff) begin
          if (14'(cnt_ff + 14'h1) >= db_limit(ctrl_ff[2:0])) begin
            lvl_ff[g] <= sync2_ff[g];
            cnt_ff    <= 14'h0;
          end else begin
            cnt_ff <= 14'(cnt_ff + 14'h1);
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_bidir_out    <= 2'h0;
      o_bidir_oe     <= 2'h0;
      o_track_enable <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        logic [1:0] fn;
        logic       lv;
        fn = i[0] ? cfg23_ff[5:4] : cfg23_ff[1:0];
        lv = ~(pin_mode[i+2] ^ pin_type[i+2]);
        unique case (fn)
          FN_OPEN: begin
            o_bidir_out[i] <= 1'b0;
            o_bidir_oe[i]  <= !lv;
          end
          FN_PUSH: begin
            o_bidir_out[i] <= lv;
            o_bidir_oe[i]  <= 1'b1;
          end
          default: begin
            o_bidir_out[i] <= 1'b0;
            o_bidir_oe[i]  <= 1'b0;
          end
        endcase
      end
      o_track_enable <= (cfg01_ff[1:0] == FN_TRACK) && pin_act[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event detection, clearing and interrupt.
  assign new_lo = {1'b0, uv && !uv_prev_ff, 1'b0,
                   pin_act & ~act_prev_ff & pin_is_in};
  assign new_hi = {2'h0,
                   sup.overcurrent & ~sup_prev_ff[5:4] &
                   ~msk_hi_ff[5:4],
                   sup.thermal_shutdown_flag && !sup_prev_ff[3],
                   sup.thermal_warning && !sup_prev_ff[2],
                   ~sup.in_range & sup_prev_ff[1:0]};
  assign clr_lo = (wr_ok && full_addr == ADDR_EVT_LO) ? i_acc.wdata : 8'h00;
  assign clr_hi = (wr_ok && full_addr == ADDR_EVT_HI) ? i_acc.wdata : 8'h00;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sup_prev_ff <= 8'h00;
      uv_prev_ff  <= 1'b0;
      // Pins read low at reset, which is active for the default polarity.
      // Starting from active keeps a false pin event from following reset.
      act_prev_ff <= '1;
    end else begin
      sup_prev_ff <= sup;
      uv_prev_ff  <= uv;
      act_prev_ff <= pin_act;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      evt_lo_ff  <= REG_RESET;
      evt_hi_ff  <= REG_RESET;
      pend_lo_ff <= REG_RESET;
      pend_hi_ff <= REG_RESET;
    end else begin
      // Events of a clearing cycle wait one cycle, so the clear cannot eat
      // them.
      evt_lo_ff  <= (evt_lo_ff & ~clr_lo) | pend_lo_ff |
                    ((clr_lo != 8'h00) ? 8'h00 : new_lo);
      evt_hi_ff  <= (evt_hi_ff & ~clr_hi) | pend_hi_ff |
                    ((clr_hi != 8'h00) ? 8'h00 : new_hi);
      pend_lo_ff <= (clr_lo != 8'h00) ? new_lo : 8'h00;
      pend_hi_ff <= (clr_hi != 8'h00) ? new_hi : 8'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_interrupt_out_n <= 1'b1;
    end else begin
      o_interrupt_out_n <= !(|(evt_lo_ff & ~msk_lo_ff) ||
                             |(evt_hi_ff & ~msk_hi_ff));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Voltage step timing per rail, running while the rail ramps.
  generate
    for (g = 0; g < 2; g++) begin : g_rail
      logic [8:0] cnt_ff;
      logic [1:0] code;
      assign code = g ? ctrl_ff[6:5] : ctrl_ff[4:3];
      always_ff @(posedge i_clk) begin
        if (!i_rst_n || sup.ramp_ready[g]) begin
          cnt_ff              <= 9'h0;
          o_rail_step_tick[g] <= 1'b0;
        end else if (cnt_ff >= 9'(slew_limit(code) - 9'h1)) begin
          cnt_ff              <= 9'h0;
          o_rail_step_tick[g] <= 1'b1;
        end else begin
          cnt_ff              <= 9'(cnt_ff + 9'h1);
          o_rail_step_tick[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule : pevg_regs

// File: tb/pevg_regs_monitor.sv
// Purpose: Port-level checks of the page, event and pin register block.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Sees only the top ports; bound in after the module.
`timescale 1ns/1ns
module pevg_regs_monitor
  import pevg_pkg::*;
#(
  parameter int unsigned DB_TICK_LEN = DB_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic         i_clk,
  input wire logic         i_rst_n,
  // Register access.
  input wire pevg_acc_t    i_acc,
  input wire logic         i_if_four_wire,
  input wire logic [7:0]   o_rdata,
  input wire logic         o_rvalid,
  input wire logic         o_ext_wr,
  input wire logic         o_ext_rd,
  input wire logic [9:0]   o_ext_addr,
  input wire logic [7:0]   o_ext_wdata,
  input wire logic [7:0]   i_ext_rdata,
  // Monitored signals and pins.
  input wire pevg_supply_t i_supply,
  input wire logic         i_io_supply_undervoltage,
  input wire logic [4:0]   i_pin_in,
  input wire logic [1:0]   o_bidir_out,
  input wire logic [1:0]   o_bidir_oe,
  input wire logic         o_track_enable,
  input wire logic [1:0]   o_rail_step_tick,
  input wire logic         o_interrupt_out_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  //////////////////////////////////////////////////////////////////////////
  // A release of the interrupt needs a recent write, clear or mask.
  logic [1:0] wr_age_ff;
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || (i_acc.valid && i_acc.write)) begin
      wr_age_ff <= 2'h0;
    end else if (wr_age_ff != 2'h3) begin
      wr_age_ff <= wr_age_ff + 2'h1;
    end
  end
  sequence rd_req;
    i_acc.valid && !i_acc.write;
  endsequence
  property p_gap(logic tick);
    tick |=> !tick [*8];
  endproperty
  //////////////////////////////////////////////////////////////////////////
  chk_read_answer: assert property (rd_req |-> ##2 o_rvalid)
    else $error("read not answered after two cycles");
  chk_rvalid_cause: assert property (
    o_rvalid |-> $past(i_acc.valid && !i_acc.write, 2))
    else $error("read data valid without a read");
  chk_rdata_hold: assert property (!o_rvalid |-> $stable(o_rdata))
    else $error("read data moved without a read");
  chk_extwr_data: assert property (o_ext_wr |->
    $past(i_acc.valid && i_acc.write) && o_ext_wdata == $past(i_acc.wdata))
    else $error("external write not from the last access");
  chk_extrd_cause: assert property (
    o_ext_rd |-> $past(i_acc.valid && !i_acc.write))
    else $error("external read without a read");
  chk_reset_quiet: assert property ($rose(i_rst_n) |->
    o_interrupt_out_n && !o_rvalid && o_bidir_oe == 2'h0 && o_rdata == 8'h00)
    else $error("outputs not idle after reset");
  chk_irq_release: assert property (
    $rose(o_interrupt_out_n) |-> wr_age_ff < 2'h3)
    else $error("interrupt released without a write");
  chk_step_gap_a: assert property (p_gap(o_rail_step_tick[0]))
    else $error("rail A steps too close");
  chk_step_gap_b: assert property (p_gap(o_rail_step_tick[1]))
    else $error("rail B steps too close");
endmodule // pevg_regs_monitor

bind pevg_regs pevg_regs_monitor #(.DB_TICK_LEN(DB_TICK_LEN)) mon_u (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_acc(i_acc),
  .i_if_four_wire(i_if_four_wire), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
  .o_ext_wr(o_ext_wr), .o_ext_rd(o_ext_rd), .o_ext_addr(o_ext_addr),
  .o_ext_wdata(o_ext_wdata), .i_ext_rdata(i_ext_rdata), .i_supply(i_supply),
  .i_io_supply_undervoltage(i_io_supply_undervoltage),
  .i_pin_in(i_pin_in), .o_bidir_out(o_bidir_out), .o_bidir_oe(o_bidir_oe),
  .o_track_enable(o_track_enable), .o_rail_step_tick(o_rail_step_tick),
  .o_interrupt_out_n(o_interrupt_out_n)
);

// File: tb/pevg_host.sv
// Purpose: Host model issuing byte accesses to the register block.
// Assumes: Requests change at the falling edge and last one cycle.
// Notes:   A read that gets no answer returns unknown data.
`timescale 1ns/1ns
module pevg_host
  import pevg_pkg::*;
(
  // Clock.
  input  wire logic       i_clk,
  // Access toward the block.
  output pevg_acc_t       o_acc,
  // Read answer.
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid
);
  initial o_acc = '0;
  task automatic beat(input logic w, b, input logic [7:0] a, d);
    @(negedge i_clk);
    o_acc = '{valid: 1'b1, write: w, burst: b, done: 1'b0,
              addr: a, wdata: d};
    @(negedge i_clk);
    o_acc = '0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    beat(1'b1, 1'b0, a, d);
  endtask
  task automatic bwr(input logic [7:0] a, d);
    beat(1'b1, 1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'hxx;
    beat(1'b0, 1'b0, a, 8'h00);
    repeat (3) begin
      @(negedge i_clk);
      if (i_rvalid === 1'b1) d = i_rdata;
    end
  endtask
  // Clearing writes back what was read, so new flags are never lost.
  task automatic clr(input logic [7:0] a);
    logic [7:0] v;
    rd(a, v);
    wr(a, v);
  endtask
  task automatic fin();
    @(negedge i_clk);
    o_acc.done = 1'b1;
    @(negedge i_clk);
    o_acc = '0;
  endtask
endmodule // pevg_host

// File: tb/pevg_regs_tb.sv
// Purpose: Self-checking bench of the page, event and pin register block.
// Assumes: Inputs change at the falling edge; debounce tick is shortened.
// Notes:   No debounce filter time is run.
`timescale 1ns/1ns
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin \
  bad_count++; $display("CHECK FAILED t=%0t %s", $time, m); end end
module pevg_regs_tb;
  import pevg_pkg::*;
  logic         i_clk, i_rst_n, i_if_four_wire, i_io_supply_undervoltage;
  logic         o_rvalid, o_ext_wr, o_ext_rd, o_track_enable;
  logic         o_interrupt_out_n;
  logic [4:0]   i_pin_in;
  pevg_acc_t    i_acc;
  pevg_supply_t i_supply;
  logic [7:0]   o_rdata, o_ext_wdata, i_ext_rdata, rd_v;
  logic [9:0]   o_ext_addr;
  logic [1:0]   o_bidir_out, o_bidir_oe, o_rail_step_tick;
  int           bad_count, compares, n;
  logic [23:0]  rows [11] = '{24'h52ff00, 24'h53ff00, 24'h54ff5f,
    24'h55ff3f, 24'h5aff0f, 24'h54ff5f, 24'h540000, 24'h550000,
    24'h5a0404, 24'h50ff00, 24'h51ff00};
  logic [11:0]  pins [4] = '{12'hf2a, 12'h3ae, 12'h7e8, 12'h000};
  pevg_host h (.i_clk(i_clk), .o_acc(i_acc), .i_rdata(o_rdata),
    .i_rvalid(o_rvalid));
  pevg_regs #(.DB_TICK_LEN(4)) dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_acc(i_acc), .i_if_four_wire(i_if_four_wire), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .o_ext_wr(o_ext_wr), .o_ext_rd(o_ext_rd),
    .o_ext_addr(o_ext_addr), .o_ext_wdata(o_ext_wdata),
    .i_ext_rdata(i_ext_rdata), .i_supply(i_supply),
    .i_io_supply_undervoltage(i_io_supply_undervoltage),
    .i_pin_in(i_pin_in), .o_bidir_out(o_bidir_out),
    .o_bidir_oe(o_bidir_oe), .o_track_enable(o_track_enable),
    .o_rail_step_tick(o_rail_step_tick),
    .o_interrupt_out_n(o_interrupt_out_n));
  // Outside registers answer the inverse of their address.
  assign i_ext_rdata = ~o_ext_addr[7:0];
  //////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge i_clk);
  endtask
  task automatic wx(input logic [7:0] a, input logic f, logic [9:0] ea);
    h.wr(a, 8'h5a);
    `CHK(o_ext_wr, f, "external write strobe")
    if (f) `CHK(o_ext_addr, ea, "external address")
  endtask
  task automatic gap(input int r, output int k);
    k = 0;
    while (o_rail_step_tick[r] !== 1'b1 && k < 1000) begin
      @(negedge i_clk);
      k++;
    end
    k = 0;
    do begin
      @(negedge i_clk);
      k++;
    end while (o_rail_step_tick[r] !== 1'b1 && k < 1000);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    #300000;
    bad_count++;
    final_report();
  end
  initial begin
    i_rst_n = 1'b0;
    i_if_four_wire = 1'b0;
    i_io_supply_undervoltage = 1'b0;
    i_pin_in = 5'h00;
    i_supply = '0;
    cyc(3);
    i_rst_n = 1'b1;
    cyc(6);
    for (int i = 0; i < 11; i++) begin
      h.wr(rows[i][23:16], rows[i][15:8]);
      h.rd(rows[i][23:16], rd_v);
      `CHK(rd_v, rows[i][7:0], "register readback")
    end
    `CHK(o_interrupt_out_n, 1'b1, "interrupt idle")
    i_supply.overcurrent[0] = 1'b1;
    i_supply.thermal_warning = 1'b1;
    cyc(6);
    `CHK(o_interrupt_out_n, 1'b0, "interrupt asserted")
    h.rd(8'h51, rd_v);
    `CHK(rd_v, 8'h14, "supply status")
    h.rd(8'h53, rd_v);
    `CHK(rd_v, 8'h14, "event flags")
    h.wr(8'h53, 8'h10);
    h.rd(8'h53, rd_v);
    `CHK(rd_v, 8'h04, "partial clear")
    h.clr(8'h53);
    cyc(3);
    `CHK(o_interrupt_out_n, 1'b1, "interrupt released")
    h.wr(8'h55, 8'h14);
    i_supply = '0;
    cyc(6);
    i_supply.overcurrent[0] = 1'b1;
    i_supply.thermal_warning = 1'b1;
    cyc(6);
    h.rd(8'h53, rd_v);
    `CHK(rd_v, 8'h04, "masked flags")
    `CHK(o_interrupt_out_n, 1'b1, "masked interrupt")
    h.wr(8'h55, 8'h00);
    cyc(3);
    `CHK(o_interrupt_out_n, 1'b0, "unmasked interrupt")
    h.clr(8'h53);
    // Sweep the new event across the clearing cycle.
    for (int k = 0; k < 5; k++) begin
      i_supply.thermal_warning = 1'b0;
      cyc(6);
      i_supply.thermal_warning = 1'b1;
      cyc(6);
      i_supply.thermal_shutdown_flag = 1'b1;
      cyc(k);
      h.wr(8'h53, 8'h04);
      cyc(6);
      h.rd(8'h53, rd_v);
      `CHK(rd_v, 8'h08, "event during clear")
      i_supply.thermal_shutdown_flag = 1'b0;
      h.wr(8'h53, 8'h08);
    end
    i_supply.in_range = 2'h3;
    cyc(6);
    i_supply.in_range = 2'h1;
    i_io_supply_undervoltage = 1'b1;
    i_pin_in[4] = 1'b1;
    cyc(6);
    h.rd(8'h53, rd_v);
    `CHK(rd_v, 8'h02, "power loss event")
    h.rd(8'h52, rd_v);
    `CHK(rd_v, 8'h50, "supply and pin events")
    h.rd(8'h50, rd_v);
    `CHK(rd_v, 8'h10, "pin level")
    wx(8'hd0, 1'b1, 10'h0d0);
    h.wr(8'h56, 8'h80);
    wx(8'hd0, 1'b0, 10'h0d0);
    wx(8'hcf, 1'b1, 10'h0cf);
    h.wr(8'h00, 8'h02);
    wx(8'h4f, 1'b0, 10'h14f);
    wx(8'h50, 1'b1, 10'h150);
    h.wr(8'h00, 8'h04);
    wx(8'h05, 1'b1, 10'h205);
    h.wr(8'h00, 8'h00);
    h.wr(8'h56, 8'h00);
    h.wr(8'h54, 8'h01);
    h.bwr(8'h00, 8'h02);
    h.rd(8'h55, rd_v);
    `CHK(rd_v, 8'h02, "page write mode")
    h.wr(8'h00, 8'h40);
    h.bwr(8'h54, 8'h03);
    h.rd(8'h54, rd_v);
    `CHK(rd_v, 8'h03, "repeated write mode")
    i_if_four_wire = 1'b1;
    h.wr(8'h00, 8'h81);
    h.rd(8'h50, rd_v);
    `CHK(rd_v, 8'h2f, "external read data")
    wx(8'h50, 1'b1, 10'h0d0);
    h.fin();
    h.rd(8'h00, rd_v);
    `CHK(rd_v, 8'h80, "page back to zero")
    for (int i = 1; i < 3; i++) begin
      h.wr(8'h00, 8'(2 * i));
      wx(8'h10, 1'b1, 10'(i * 256 + 16));
      h.wr(8'h00, 8'h00);
    end
    i_if_four_wire = 1'b0;
    for (int i = 0; i < 4; i++) begin
      h.wr(8'h59, pins[i][11:4]);
      cyc(2);
      `CHK(o_bidir_oe, pins[i][3:2], "pin drive")
      `CHK(o_bidir_out & o_bidir_oe, pins[i][1:0], "pin out")
    end
    h.wr(8'h58, 8'h05);
    i_pin_in[0] = 1'b1;
    cyc(6);
    `CHK(o_track_enable, 1'b1, "track enable on")
    h.wr(8'h58, 8'h04);
    cyc(3);
    `CHK(o_track_enable, 1'b0, "track enable off")
    for (int c = 0; c < 4; c++) begin
      h.wr(8'h56, 8'(c << 3));
      gap(0, n);
      gap(0, n);
      `CHK(n, (SLEW_T0_NS / CLK_PERIOD_NS) >> c, "rail A step")
    end
    h.wr(8'h56, 8'h60);
    gap(1, n);
    gap(1, n);
    `CHK(n, SLEW_T3_NS / CLK_PERIOD_NS, "rail B step")
    i_supply.ramp_ready = 2'h3;
    cyc(5);
    n = 0;
    repeat (500) begin
      @(negedge i_clk);
      if (o_rail_step_tick != 2'h0) n++;
    end
    `CHK(n, 0, "no steps while ready")
    i_rst_n = 1'b0;
    cyc(3);
    i_rst_n = 1'b1;
    h.rd(8'h56, rd_v);
    `CHK(rd_v, REG_RESET, "reset value")
    final_report();
  end
endmodule // pevg_regs_tb
